/* File: fssb_bench.sv */
// fssb_bench.sv: self-checking bench for the fault summary byte
// assumes: fssb_top, fssb_host and fssb_checker compiled before it
`timescale 1ns/1ps
`default_nettype none

module fssb_bench;
    logic        clk_sys = 1'b0;
    logic        reset_n;
    logic        rd_strobe;
    logic [7:0]  rd_command;
    logic [7:0]  page_sel;
    logic [7:0]  rd_data_ff;
    logic        rd_valid_ff;
    logic        rd_unsupported_ff;
    logic        smb_alert_ff;
    logic [21:0] p;
    int          fails = 0;
    int          num_checks = 0;
    int          seed = 52;
    int          r;
    always #2 clk_sys = ~clk_sys;
    fssb_top u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .rd_strobe(rd_strobe), .rd_command(rd_command), .page_sel(page_sel),
        .is_slave(p[1:0]), .output_on(p[3:2]), .soft_start_done(p[5:4]),
        .output_overvoltage_flag(p[7:6]), .output_undervoltage_fault(p[9:8]),
        .power_good_fault(p[11:10]), .output_overcurrent_flag(p[13:12]),
        .overcurrent_warning(p[15:14]), .overtemp_fault_input(p[17:16]),
        .overtemp_warning_input(p[19:18]), .input_undervoltage_flag(p[20]),
        .cml_fault(p[21]), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff),
        .rd_unsupported_ff(rd_unsupported_ff), .smb_alert_ff(smb_alert_ff));
    fssb_host u_host (.clk_sys(clk_sys), .rd_strobe(rd_strobe),
        .rd_command(rd_command), .page_sel(page_sel), .rd_data_ff(rd_data_ff),
        .rd_valid_ff(rd_valid_ff), .rd_unsupported_ff(rd_unsupported_ff));
    function automatic logic [7:0] model(input int c);
        logic [7:0] b;
        b = 8'h00;
        b[6] = !p[2+c];
        b[5] = p[6+c] & !p[c];
        b[4] = p[12+c];
        b[3] = (c == 0) & p[20] & p[4];
        b[2] = p[16+c] | p[18+c];
        b[1] = p[21];
        b[0] = ((p[8+c] | p[10+c]) & !p[c]) | p[14+c];
        return b;
    endfunction
    task automatic cmp(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic rd(input logic [7:0] pg, input logic [7:0] cmd);
        logic [7:0] d;
        logic [7:0] e;
        logic       v;
        logic       u;
        logic       eu;
        eu = cmd != 8'h78 || !(pg inside {8'h00, 8'h01, 8'h11});
        e = eu ? 8'h00 : model(pg == 8'h01);
        u_host.read(cmd, pg, d, v, u);
        cmp(v === 1'b1 && u === eu && d === e, "summary read");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge clk_sys);
        fails++;
        wrap_up;
    end
    initial begin
        reset_n = 1'b0;
        p = 22'h00_0000;
        repeat (16) @(posedge clk_sys);
        for (int k = 0; k < 2; k++) begin
            reset_n <= 1'b1;
            @(posedge clk_sys);
            cmp(rd_data_ff === 8'h00 && smb_alert_ff === 1'b0, "reset");
            for (int i = 0; i < 40; i++) begin
                r = $random(seed) & $random(seed);
                p <= r[21:0];
                repeat (10) @(posedge clk_sys);
                rd(8'h00, 8'h78);
                rd(8'h01, 8'h78);
                rd(8'h11, 8'h78);
                cmp(smb_alert_ff === |(p[7:6] & ~p[1:0]), "alert");
                rd(8'h02, 8'h78);
                rd(8'h00, 8'h79);
            end
            reset_n <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
        wrap_up;
    end
endmodule

bind fssb_top fssb_checker u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
    .rd_strobe(rd_strobe), .rd_command(rd_command), .page_sel(page_sel),
    .is_slave(is_slave), .output_overvoltage_flag(output_overvoltage_flag),
    .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff),
    .rd_unsupported_ff(rd_unsupported_ff), .smb_alert_ff(smb_alert_ff));
`default_nettype wire

/* File: fssb_chan.v */
// fssb_chan.v: builds the summary byte of one channel from its fault levels
// assumes: all inputs already synchronised to clk_sys
`timescale 1ns/1ps
`default_nettype none

module fssb_chan (
    input  wire       clk_sys,
    input  wire       reset_n,
    input  wire       is_slave,
    input  wire       has_vin,
    input  wire       output_on,
    input  wire       soft_start_done,
    input  wire       output_overvoltage_flag,
    input  wire       output_undervoltage_fault,
    input  wire       power_good_fault,
    input  wire       output_overcurrent_flag,
    input  wire       overcurrent_warning,
    input  wire       input_undervoltage_flag,
    input  wire       overtemp_fault_input,
    input  wire       overtemp_warning_input,
    input  wire       cml_fault,
    output reg  [7:0] summary_ff
);

`include "fssb_consts.vh"

reg [7:0] nxt_summary;
reg       ov_ok;

always @* begin
    nxt_summary = `FSSB_SUMMARY_RESET;
    ov_ok = ~is_slave;
    nxt_summary[`FSSB_BIT_ZERO]  = 1'b0;
    nxt_summary[`FSSB_BIT_OFF]   = ~output_on;
    nxt_summary[`FSSB_BIT_OVF]   = ov_ok & output_overvoltage_flag;
    nxt_summary[`FSSB_BIT_OCF]   = output_overcurrent_flag;
    nxt_summary[`FSSB_BIT_VINUV] = has_vin & soft_start_done
                                   & input_undervoltage_flag;
    nxt_summary[`FSSB_BIT_OVERTEMP_FAULT_OR_WARNING_FLAG]  = overtemp_fault_input
                                   | overtemp_warning_input;
    nxt_summary[`FSSB_BIT_CML]   = cml_fault;
    nxt_summary[`FSSB_BIT_OTH]   = (ov_ok & (output_undervoltage_fault
                                   | power_good_fault))
                                   | overcurrent_warning;
end

always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        summary_ff <= `FSSB_SUMMARY_RESET;
    end else begin
        summary_ff <= nxt_summary;
    end
end

endmodule

`default_nettype wire

/* File: fssb_checker.sv */
// fssb_checker.sv: concurrent checks on the fault summary top ports
// assumes: bound to fssb_top, one clock domain clk_sys
`timescale 1ns/1ps
`default_nettype none

module fssb_checker (
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic       rd_strobe,
    input wire logic [7:0] rd_command,
    input wire logic [7:0] page_sel,
    input wire logic [1:0] is_slave,
    input wire logic [1:0] output_overvoltage_flag,
    input wire logic [7:0] rd_data_ff,
    input wire logic       rd_valid_ff,
    input wire logic       rd_unsupported_ff,
    input wire logic       smb_alert_ff
);
    logic [2:0] slv_ff;
    logic [2:0] ov_ff;
    logic       good_req;
    // saturating run length of a pin level
    function automatic logic [2:0] nxt_run(input logic [2:0] n, input logic c);
        return c ? ((n == 3'h7) ? n : n + 3'h1) : 3'h0;
    endfunction
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            slv_ff <= 3'h0;
            ov_ff  <= 3'h0;
        end else begin
            slv_ff <= nxt_run(slv_ff, is_slave[0]);
            ov_ff  <= nxt_run(ov_ff,
                              output_overvoltage_flag[0] & !is_slave[0]);
        end
    end
    assign good_req = rd_command == 8'h78 &&
                      page_sel inside {8'h00, 8'h01, 8'h11};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    chk_good_answer: assert property (
        rd_strobe && good_req |=> rd_valid_ff && !rd_unsupported_ff)
        else $error("good read not answered");
    chk_refused_zero: assert property (
        rd_strobe && !good_req |=> rd_unsupported_ff && rd_data_ff == 8'h00)
        else $error("bad read not refused");
    chk_top_bit: assert property (rd_valid_ff |-> !rd_data_ff[7])
        else $error("bit 7 set");
    chk_slave_ov: assert property (
        rd_strobe && good_req && page_sel == 8'h00 && slv_ff == 3'h7
        |=> !rd_data_ff[5]) else $error("slave shows overvoltage");
    chk_alert_ov: assert property (ov_ff == 3'h7 |-> smb_alert_ff)
        else $error("alert missing");
    chk_page1_vin: assert property (
        rd_valid_ff && $past(page_sel) == 8'h01 |-> !rd_data_ff[3])
        else $error("page 1 input undervoltage");
    chk_reset_zero: assert property (
        $rose(reset_n) |-> rd_data_ff == 8'h00 && !rd_valid_ff)
        else $error("outputs not zero after reset");
    chk_data_hold: assert property (
        !rd_strobe |=> $stable(rd_data_ff)) else $error("data moved");
    cover property (rd_valid_ff && rd_unsupported_ff);
    cover property (rd_strobe && page_sel == 8'h11);
    cover property ($rose(smb_alert_ff));
endmodule
`default_nettype wire

/* File: fssb_consts.vh */
// fssb_consts.vh: command code, reset value, bit positions and page codes for the fault summary
// assumes: included by bare name from the fault summary design files
`ifndef FSSB_CONSTS_VH
`define FSSB_CONSTS_VH

`define FSSB_CMD_SUMMARY      8'h78
`define FSSB_SUMMARY_RESET    8'h00
`define FSSB_PAGE_CH1         8'h00
`define FSSB_PAGE_CH2         8'h01
`define FSSB_PAGE_BOTH        8'h11
`define FSSB_BIT_ZERO         7
`define FSSB_BIT_OFF          6
`define FSSB_BIT_OVF          5
`define FSSB_BIT_OCF          4
`define FSSB_BIT_VINUV        3
`define FSSB_BIT_OVERTEMP_FAULT_OR_WARNING_FLAG         2
`define FSSB_BIT_CML          1
`define FSSB_BIT_OTH          0

`endif

/* File: fssb_host.sv */
// fssb_host.sv: management bus host model issuing summary reads
// assumes: answer flops change on the edge that takes the strobe, one cycle after it is driven
`timescale 1ns/1ps
`default_nettype none

module fssb_host (
    input  wire logic       clk_sys,
    output var  logic       rd_strobe,
    output var  logic [7:0] rd_command,
    output var  logic [7:0] page_sel,
    input  wire logic [7:0] rd_data_ff,
    input  wire logic       rd_valid_ff,
    input  wire logic       rd_unsupported_ff
);
    initial begin
        rd_strobe = 1'b0;
        rd_command = 8'h00;
        page_sel = 8'h00;
    end
    task automatic read(input logic [7:0] cmd, input logic [7:0] pg,
                        output logic [7:0] d, output logic v, output logic u);
        @(posedge clk_sys);
        rd_strobe <= 1'b1;
        rd_command <= cmd;
        page_sel <= pg;
        @(posedge clk_sys);
        rd_strobe <= 1'b0;
        rd_command <= ~cmd;
        // answer flops change on the taking edge: read them mid-cycle
        @(negedge clk_sys);
        d = rd_data_ff;
        v = rd_valid_ff;
        u = rd_unsupported_ff;
        @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

/* File: fssb_top.v */
// fssb_top.v: critical fault summary byte, paged over two channels
// assumes: command/page come from the bus engine on clk_sys; faults are pins
//
// Overview of operation
// - reading command 78h returns one summary byte for the selected channel.
// - page 0 selects channel 1, page 1 channel 2, page 11 both.
// - a master channel reports only its own channel's faults.
// - a slave holds overvoltage, undervoltage and power-good faults at zero.
// - current and temperature flags report per channel in every mode.
// - bit 6 is set whenever the channel delivers no output power.
// - bit 5 flags output overvoltage and raises alert; zero in slave.
// - bit 4 flags an output overcurrent fault.
// - bit 3 flags input undervoltage, channel 1 only (pages 0 and 11), masked before soft-start.
// - bit 2 flags overtemperature fault or warning input.
// - bit 1 flags communication, memory or logic fault.
// - bit 0 flags any other fault or warning, e.g. undervoltage.
`timescale 1ns/1ps
`default_nettype none

module fssb_top (
    input  wire       clk_sys,
    input  wire       reset_n,
    input  wire       rd_strobe,
    input  wire [7:0] rd_command,
    input  wire [7:0] page_sel,
    input  wire [1:0] is_slave,
    input  wire [1:0] output_on,
    input  wire [1:0] soft_start_done,
    input  wire [1:0] output_overvoltage_flag,
    input  wire [1:0] output_undervoltage_fault,
    input  wire [1:0] power_good_fault,
    input  wire [1:0] output_overcurrent_flag,
    input  wire [1:0] overcurrent_warning,
    input  wire       input_undervoltage_flag,
    input  wire [1:0] overtemp_fault_input,
    input  wire [1:0] overtemp_warning_input,
    input  wire       cml_fault,
    output reg  [7:0] rd_data_ff,
    output reg        rd_valid_ff,
    output reg        rd_unsupported_ff,
    output reg        smb_alert_ff
);

`include "fssb_consts.vh"

localparam NPIN = 17;

////////////////////////////////////////////////////////////////////////////
// two-stage synchronisers for the level pins other than temperature and cml
wire [NPIN-1:0] pin_raw;
reg  [NPIN-1:0] meta_ff;
reg  [NPIN-1:0] sync_ff;

assign pin_raw = {is_slave, output_on, soft_start_done,
                  output_overvoltage_flag, output_undervoltage_fault,
                  power_good_fault, output_overcurrent_flag,
                  overcurrent_warning, input_undervoltage_flag};

always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        meta_ff <= {NPIN{1'b0}};
        sync_ff <= {NPIN{1'b0}};
    end else begin
        meta_ff <= pin_raw;
        sync_ff <= meta_ff;
    end
end

wire [1:0] s_slave = sync_ff[16:15];
wire [1:0] s_on    = sync_ff[14:13];
wire [1:0] s_ss    = sync_ff[12:11];
wire [1:0] s_ov    = sync_ff[10:9];
wire [1:0] s_uv    = sync_ff[8:7];
wire [1:0] s_pg    = sync_ff[6:5];
wire [1:0] s_oc    = sync_ff[4:3];
wire [1:0] s_ocw   = sync_ff[2:1];
wire       s_vin   = sync_ff[0];

// separate two-stage path for temperature and cml inputs
reg [1:0] meta_otf_ff;
reg [1:0] sync_otf_ff;
reg [1:0] meta_otw_ff;
reg [1:0] sync_otw_ff;
reg       meta_cml_ff;
reg       sync_cml_ff;

always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        meta_otf_ff <= 2'h0;
        sync_otf_ff <= 2'h0;
        meta_otw_ff <= 2'h0;
        sync_otw_ff <= 2'h0;
        meta_cml_ff <= 1'b0;
        sync_cml_ff <= 1'b0;
    end else begin
        meta_otf_ff <= overtemp_fault_input;
        sync_otf_ff <= meta_otf_ff;
        meta_otw_ff <= overtemp_warning_input;
        sync_otw_ff <= meta_otw_ff;
        meta_cml_ff <= cml_fault;
        sync_cml_ff <= meta_cml_ff;
    end
end

wire [1:0] s_otf   = sync_otf_ff;
wire [1:0] s_otw   = sync_otw_ff;
wire       s_cml   = sync_cml_ff;

////////////////////////////////////////////////////////////////////////////
// per-channel summary builders
wire [7:0] sum_ch1;
wire [7:0] sum_ch2;

fssb_chan u_ch1 (
    .clk_sys                   (clk_sys),
    .reset_n                   (reset_n),
    .is_slave                  (s_slave[0]),
    .has_vin                   (1'b1),
    .output_on                 (s_on[0]),
    .soft_start_done           (s_ss[0]),
    .output_overvoltage_flag   (s_ov[0]),
    .output_undervoltage_fault (s_uv[0]),
    .power_good_fault          (s_pg[0]),
    .output_overcurrent_flag   (s_oc[0]),
    .overcurrent_warning       (s_ocw[0]),
    .input_undervoltage_flag   (s_vin),
    .overtemp_fault_input      (s_otf[0]),
    .overtemp_warning_input    (s_otw[0]),
    .cml_fault                 (s_cml),
    .summary_ff                (sum_ch1)
);

fssb_chan u_ch2 (
    .clk_sys                   (clk_sys),
    .reset_n                   (reset_n),
    .is_slave                  (s_slave[1]),
    .has_vin                   (1'b0),
    .output_on                 (s_on[1]),
    .soft_start_done           (s_ss[1]),
    .output_overvoltage_flag   (s_ov[1]),
    .output_undervoltage_fault (s_uv[1]),
    .power_good_fault          (s_pg[1]),
    .output_overcurrent_flag   (s_oc[1]),
    .overcurrent_warning       (s_ocw[1]),
    .input_undervoltage_flag   (s_vin),
    .overtemp_fault_input      (s_otf[1]),
    .overtemp_warning_input    (s_otw[1]),
    .cml_fault                 (s_cml),
    .summary_ff                (sum_ch2)
);

////////////////////////////////////////////////////////////////////////////
// read port: page decode and answer
reg [7:0] nxt_rd_data;
reg       nxt_unsup;

always @* begin
    nxt_rd_data = `FSSB_SUMMARY_RESET;
    nxt_unsup   = 1'b0;
    if (rd_command == `FSSB_CMD_SUMMARY) begin
        case (page_sel)
            `FSSB_PAGE_CH1: begin
                nxt_rd_data = sum_ch1;
            end
            `FSSB_PAGE_CH2: begin
                nxt_rd_data = sum_ch2;
            end
            `FSSB_PAGE_BOTH: begin
                // both channels at once: the byte shows channel 1
                nxt_rd_data = sum_ch1;
            end
            default: begin
                nxt_unsup = 1'b1;
            end
        endcase
    end else begin
        nxt_unsup = 1'b1;
    end
end

always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        rd_data_ff        <= `FSSB_SUMMARY_RESET;
        rd_valid_ff       <= 1'b0;
        rd_unsupported_ff <= 1'b0;
        smb_alert_ff      <= 1'b0;
    end else begin
        rd_valid_ff       <= rd_strobe;
        rd_unsupported_ff <= rd_strobe & nxt_unsup;
        if (rd_strobe) begin
            rd_data_ff <= nxt_rd_data;
        end
        smb_alert_ff <= sum_ch1[`FSSB_BIT_OVF]
                        | sum_ch2[`FSSB_BIT_OVF];
    end
end

endmodule

`default_nettype wire
